/* File: common/fep_pkg.sv */
// ****************************************************************
// Constants and types of the flash command controller
// ****************************************************************
package fep_pkg;
  // Clock rate
  localparam int CLK_MHZ = 50;
  localparam int CLK_NS = 20;
  // Pin timing in its own unit, then in cycles (minimums round up)
  localparam int WE_LOW_NS = 100;
  localparam int RD_ACC_NS = 120;
  localparam int RST_LOW_NS = 500;
  localparam int RST_REC_NS = 1000;
  localparam int PWRUP_MS = 10;
  localparam int WE_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC = (RD_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_LOW_CYC = (RST_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_REC_CYC = (RST_REC_NS + CLK_NS - 1) / CLK_NS;
  localparam int PWRUP_CYC = PWRUP_MS * 1000 * CLK_MHZ;
  localparam int SYNC_CYC = 2;
  // Default poll limit, counted in polls of one full read cycle each
  localparam int POLL_LIMIT_DEF = 1000000000;
  // Last sub-step inside one bus cycle or reset phase
  localparam logic [7:0] WR_END = 8'(WE_CYC + 1);
  localparam logic [7:0] RD_END = 8'(RD_CYC + SYNC_CYC + 1);
  localparam logic [7:0] RL_END = 8'(RST_LOW_CYC - 1);
  localparam logic [7:0] RR_END = 8'(RST_REC_CYC - 1);
  // Command addresses and codes
  localparam logic [18:0] UNL_ADDR1 = 19'h05555;
  localparam logic [18:0] UNL_ADDR2 = 19'h02AAA;
  localparam logic [7:0] UNL_DATA1 = 8'hAA;
  localparam logic [7:0] UNL_DATA2 = 8'h55;
  localparam logic [7:0] CODE_ERASE = 8'h80;
  localparam logic [7:0] CODE_PROG = 8'hA0;
  localparam logic [7:0] CODE_IDENT = 8'h90;
  localparam logic [7:0] CODE_CHIP = 8'h10;
  localparam logic [7:0] CODE_SECT = 8'h30;
  localparam logic [7:0] CODE_LOCK = 8'h40;
  localparam logic [7:0] CODE_EXIT = 8'hF0;
  // Status bit positions on the flash data bus
  localparam int POLL_DATA_BIT = 7;
  localparam int TOGGLE_STATUS_BIT = 6;
  localparam int LOCK_STATUS_BIT = 0;
  // Operation codes in the control register
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_PROG = 3'h1;
  localparam logic [2:0] OP_CHIP = 3'h2;
  localparam logic [2:0] OP_SECT = 3'h3;
  localparam logic [2:0] OP_LOCK = 3'h4;
  localparam logic [2:0] OP_IDRD = 3'h5;
  localparam logic [2:0] OP_RESET = 3'h6;
  // Register word indexes (byte address is four times)
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_ADDR = 3'h1;
  localparam logic [2:0] REG_WDATA = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_RDATA = 3'h4;
  // Register fields
  localparam int CTRL_HV_BIT = 8;
  localparam int STS_BUSY = 0;
  localparam int STS_DONE = 1;
  localparam int STS_ERR = 2;
  localparam int STS_LOCK = 3;
  localparam int STS_CORRUPT = 4;
  localparam int STS_READY = 5;
  localparam int STS_POWER = 6;
  // Controller states
  typedef enum logic [2:0] {
    ST_POWER, ST_IDLE, ST_WR, ST_RD, ST_RSTLO, ST_RSTREC
  } fep_state_t;
  // Whole state of the controller
  typedef struct packed {
    fep_state_t st;
    logic [2:0] op;
    logic [2:0] idx;
    logic [7:0] cnt;
    logic [31:0] tmo;
    logic exitf;
    logic pfirst;
    logic prevtog;
    logic busy;
    logic done;
    logic err;
    logic lock;
    logic corrupt;
    logic hv;
    logic ack;
    logic [18:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [31:0] avrd;
    logic [18:0] fa;
    logic [15:0] dq_o;
    logic dq_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic frst_n;
  } fep_regs_t;
  localparam fep_regs_t REGS_RST = '{st: ST_POWER, ce_n: 1'b1,
    oe_n: 1'b1, we_n: 1'b1, frst_n: 1'b1, default: '0};
endpackage

/* File: src/fep_sync.sv */
`timescale 1ns/1ps
// ****************************************************************
// Two-flop synchroniser for the flash input pins
// ****************************************************************
module fep_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // First stage, read only by the second stage
  logic [W-1:0] meta_q;

  // Plain two-stage shift, no logic between the stages
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // fep_sync

/* File: src/fep_ctrl.sv */
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module fep_ctrl
  import fep_pkg::*;
#(
  parameter int unsigned PWRUP_CYCLES = PWRUP_CYC,
  parameter int unsigned POLL_LIMIT = POLL_LIMIT_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [18:0] fl_addr,
  output logic [15:0] fl_dq_o,
  output logic fl_dq_oe,
  input wire logic [15:0] fl_dq_i,
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n,
  output logic fl_rst_n,
  output logic fl_hv_override,
  input wire logic fl_busy_n
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  fep_regs_t s_q, s_d; // Whole state and its next value
  logic [16:0] pin_s; // Synchronised busy pin and data bus
  logic [15:0] dq_s; // Synchronised data bus
  logic rdy_s; // Synchronised ready pin

  // Number of command writes ahead of the data phase
  function automatic logic [2:0] seq_len(input logic [2:0] op);
    case (op)
      OP_PROG: seq_len = 3'h4;
      OP_CHIP, OP_SECT, OP_LOCK: seq_len = 3'h6;
      OP_IDRD: seq_len = 3'h3;
      default: seq_len = 3'h0;
    endcase
  endfunction

  // Address and data of one command write, {addr, data}
  function automatic logic [34:0] cyc_word(input logic [2:0] op,
    input logic [2:0] idx, input logic exitf, input logic [18:0] a,
    input logic [15:0] d);
    logic [7:0] code;
    code = (op == OP_PROG) ? CODE_PROG :
      (op == OP_IDRD) ? CODE_IDENT : CODE_ERASE;
    // Single-write exit, any address will do
    if (exitf)
      cyc_word = {a, 8'h00, CODE_EXIT};
    else
      case (idx)
        3'h0, 3'h3: cyc_word = (op == OP_PROG && idx == 3'h3) ?
          {a, d} : {UNL_ADDR1, 8'h00, UNL_DATA1};
        3'h1, 3'h4: cyc_word = {UNL_ADDR2, 8'h00, UNL_DATA2};
        3'h2: cyc_word = {UNL_ADDR1, 8'h00, code};
        3'h5: cyc_word = (op == OP_SECT) ? {a, 8'h00, CODE_SECT} :
          {UNL_ADDR1, 8'h00,
           (op == OP_LOCK) ? CODE_LOCK : CODE_CHIP};
        default: cyc_word = '0;
      endcase
  endfunction

  // Pins from outside are retimed before any logic looks at them
  fep_sync #(.W(17)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d({fl_busy_n, fl_dq_i}),
    .q(pin_s)
  );
  assign dq_s = pin_s[15:0];
  assign rdy_s = pin_s[16];

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Bus slave first, sequencer after, so hardware sets win clears
  always_comb
  begin
    logic [34:0] w;
    logic start;
    w = '0;
    s_d = s_q;
    start = 1'b0;
    // One wait state on every access
    s_d.ack = (avs_read | avs_write) & ~s_q.ack;
    if (avs_read && !s_q.ack)
      case (avs_address)
        REG_CTRL: s_d.avrd = {23'h0, s_q.hv, 5'h0, s_q.op};
        REG_ADDR: s_d.avrd = {13'h0, s_q.addr};
        REG_WDATA: s_d.avrd = {16'h0, s_q.wdata};
        REG_STATUS: s_d.avrd = {25'h0, s_q.st == ST_POWER, rdy_s,
          s_q.corrupt, s_q.lock, s_q.err, s_q.done, s_q.busy};
        REG_RDATA: s_d.avrd = {16'h0, s_q.rdata};
        default: s_d.avrd = '0; // Unmapped reads as zero
      endcase
    if (avs_write && s_q.ack)
      case (avs_address)
        REG_ADDR: s_d.addr = avs_writedata[18:0];
        REG_WDATA: s_d.wdata = avs_writedata[15:0];
        REG_STATUS:
        begin
          // Write one to clear
          if (avs_writedata[STS_DONE]) s_d.done = 1'b0;
          if (avs_writedata[STS_ERR]) s_d.err = 1'b0;
          if (avs_writedata[STS_CORRUPT]) s_d.corrupt = 1'b0;
        end
        REG_CTRL:
          // Reset may cut an operation short; others are dropped while busy
          if (s_q.st != ST_POWER && (!s_q.busy ||
              avs_writedata[2:0] == OP_RESET))
            start = 1'b1;
        default: ; // Unmapped writes ignored
      endcase
    if (start)
    begin
      s_d.op = avs_writedata[2:0];
      s_d.hv = avs_writedata[CTRL_HV_BIT];
      s_d.busy = 1'b1;
      s_d.done = 1'b0;
      s_d.err = 1'b0;
      s_d.idx = '0;
      s_d.cnt = '0;
      s_d.tmo = '0;
      s_d.exitf = 1'b0;
      s_d.pfirst = 1'b1;
      // The word being programmed is lost if reset hits it
      if (avs_writedata[2:0] == OP_RESET)
      begin
        s_d.corrupt = s_q.corrupt |
          (s_q.busy && s_q.op == OP_PROG);
        s_d.hv = 1'b0;
        s_d.st = ST_RSTLO;
      end
      else if (seq_len(avs_writedata[2:0]) == 3'h0)
        s_d.st = ST_RD;
      else
        s_d.st = ST_WR;
    end
    else
      case (s_q.st)
        // No command goes out before supply delay ends
        ST_POWER:
        begin
          s_d.tmo = s_q.tmo + 32'h1;
          if (s_q.tmo >= PWRUP_CYCLES - 1)
            s_d.st = ST_IDLE;
        end
        ST_IDLE: ;
        ST_WR:
        begin
          s_d.cnt = s_q.cnt + 8'h1;
          if (s_q.cnt == WR_END)
          begin
            s_d.cnt = '0;
            s_d.idx = s_q.idx + 3'h1;
            if (s_q.exitf)
            begin
              s_d.busy = 1'b0;
              s_d.done = 1'b1;
              s_d.st = ST_IDLE;
            end
            // Sequences run to their end unless a reset cuts them short
            else if (s_q.idx + 3'h1 < seq_len(s_q.op))
              s_d.st = ST_WR;
            else
              s_d.st = ST_RD;
          end
        end
        ST_RD:
        begin
          s_d.cnt = s_q.cnt + 8'h1;
          if (s_q.cnt == RD_END)
          begin
            s_d.cnt = '0;
            s_d.rdata = dq_s;
            if (s_q.op == OP_IDRD)
            begin
              s_d.lock = dq_s[LOCK_STATUS_BIT];
              s_d.exitf = 1'b1;
              s_d.st = ST_WR;
            end
            else if (s_q.op == OP_READ)
            begin
              s_d.busy = 1'b0;
              s_d.done = 1'b1;
              s_d.st = ST_IDLE;
            end
            // Toggle polling: done when bit six holds still
            else if (!s_q.pfirst &&
                dq_s[TOGGLE_STATUS_BIT] == s_q.prevtog)
            begin
              s_d.busy = 1'b0;
              s_d.done = 1'b1;
              s_d.hv = 1'b0;
              // Final word must match; a locked block will not
              if (s_q.op == OP_PROG && dq_s != s_q.wdata)
                s_d.err = 1'b1;
              if ((s_q.op == OP_CHIP || s_q.op == OP_SECT) &&
                  !dq_s[POLL_DATA_BIT])
                s_d.err = 1'b1;
              s_d.st = ST_IDLE;
            end
            else if (s_q.tmo >= POLL_LIMIT)
            begin
              s_d.busy = 1'b0;
              s_d.err = 1'b1;
              s_d.hv = 1'b0;
              s_d.st = ST_IDLE;
            end
            else
            begin
              s_d.pfirst = 1'b0;
              s_d.prevtog = dq_s[TOGGLE_STATUS_BIT];
              s_d.tmo = s_q.tmo + 32'h1;
            end
          end
        end
        ST_RSTLO:
        begin
          s_d.cnt = s_q.cnt + 8'h1;
          if (s_q.cnt == RL_END)
          begin
            s_d.cnt = '0;
            s_d.st = ST_RSTREC;
          end
        end
        // Device comes back in read mode after recovery
        ST_RSTREC:
        begin
          s_d.cnt = s_q.cnt + 8'h1;
          if (s_q.cnt == RR_END)
          begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
            s_d.st = ST_IDLE;
          end
        end
        default: s_d.st = ST_IDLE;
      endcase
    // Pins follow the next state so they leave flip-flops cleanly
    w = cyc_word(s_d.op, s_d.idx, s_d.exitf, s_d.addr, s_d.wdata);
    s_d.frst_n = (s_d.st != ST_RSTLO);
    s_d.ce_n = !(s_d.st == ST_WR || s_d.st == ST_RD);
    // OE stays high through every write cycle
    s_d.oe_n = !(s_d.st == ST_RD && s_d.cnt != 8'h0);
    s_d.we_n = !(s_d.st == ST_WR && s_d.cnt != 8'h0 &&
      s_d.cnt < WR_END);
    // Drive data only while writing, never against a read
    s_d.dq_oe = (s_d.st == ST_WR);
    s_d.fa = (s_d.st == ST_WR) ? w[34:16] : s_d.addr;
    s_d.dq_o = (s_d.st == ST_WR) ? w[15:0] : '0;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Asynchronous reset loads constants only
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      s_q <= REGS_RST;
    else
      s_q <= s_d;
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~s_q.ack;
  assign avs_readdata = s_q.avrd;
  assign fl_addr = s_q.fa;
  assign fl_dq_o = s_q.dq_o;
  assign fl_dq_oe = s_q.dq_oe;
  assign fl_ce_n = s_q.ce_n;
  assign fl_oe_n = s_q.oe_n;
  assign fl_we_n = s_q.we_n;
  assign fl_rst_n = s_q.frst_n;
  assign fl_hv_override = s_q.hv;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  no_contend_a: assert property (fl_dq_oe |-> fl_oe_n)
    else $error("data driven while output enable low");
  write_strobe_a: assert property (!fl_we_n |->
    !fl_ce_n && fl_oe_n)
    else $error("write strobe with bad CE or OE");
  hold_bus_a: assert property (!fl_we_n && $past(!fl_we_n) |->
    fl_addr == $past(fl_addr) && fl_dq_o == $past(fl_dq_o))
    else $error("address or data moved under write strobe");
  upper_byte_a: assert property (!fl_we_n &&
    !(s_q.op == OP_PROG && s_q.idx == 3'h3 && !s_q.exitf) |->
    fl_dq_o[15:8] == 8'h00)
    else $error("command upper byte not zero");
  power_quiet_a: assert property (s_q.st == ST_POWER |-> fl_we_n)
    else $error("write before power-up delay");
  reset_pulse_a: assert property ($fell(fl_rst_n) |->
    (!fl_rst_n)[*8])
    else $error("flash reset pulse too short");
  hv_steady_a: assert property (s_q.busy && $past(s_q.busy) &&
    s_q.st != ST_RSTLO && $past(s_q.st) != ST_IDLE |->
    fl_hv_override == $past(fl_hv_override))
    else $error("override changed during operation");
  one_wait_a: assert property ((avs_read || avs_write) &&
    $past(!(avs_read || avs_write)) |-> avs_waitrequest ##1
    !avs_waitrequest)
    else $error("bus answer not after one wait state");
  busy_end_a: assert property ($fell(s_q.busy) |->
    s_q.done || s_q.err)
    else $error("operation ended without status");
  id_exit_a: assert property ($rose(s_q.exitf) |-> ##[1:20]
    (!fl_we_n && fl_dq_o[7:0] == CODE_EXIT))
    else $error("identification exit not written");
endmodule // fep_ctrl

/* File: test/fep_flash_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// Behavioural flash device on the far side of the controller pins
// ****************************************************************
module fep_flash_model #(
  parameter int PROG_NS = 2000,
  parameter int ERASE_NS = 4000,
  parameter int PWRUP_NS = 200,
  parameter int ACC_NS = 100,
  parameter logic [15:0] MFR_CODE = 16'h00C5, // Arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h0A3B // Arbitrary value
) (
  input wire logic [18:0] addr,
  input wire logic [15:0] dq_in,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic rst_n,
  input wire logic hv,
  output logic [15:0] dq_out,
  output logic dq_drv,
  output logic busy_pull
);
  logic [15:0] mem [int]; // Sparse; absent words read as erased
  logic [18:0] a_lat, p_addr;
  logic [15:0] p_data, dq_v;
  logic arm, id_mode, locked, erasing, tog, pwr_ok, hv_op;
  int step, gen; // Sequence position; timer generation
  initial
  begin
    {arm, id_mode, locked, erasing, tog, pwr_ok, busy_pull} = '0;
    step = 0;
    gen = 0;
    #(PWRUP_NS) pwr_ok = 1'b1;
  end
  // Block of a word: boot 0, parameter 1 and 2, main 3
  function automatic int blk(input logic [18:0] a);
    return a < 19'h02000 ? 0 : a < 19'h03000 ? 1 : a < 19'h04000 ? 2 : 3;
  endfunction
  // Value on the pins: array, identification or busy status
  function automatic logic [15:0] rd_val(input logic [18:0] a);
    logic [15:0] v;
    v = mem.exists(a) ? mem[a] : 16'hFFFF;
    if (id_mode)
      v = a[1] ? {15'h0, locked} : a[0] ? DEV_CODE : MFR_CODE;
    if (busy_pull)
      v[7:6] = {erasing ? 1'b0 : ~p_data[7], tog};
    return v;
  endfunction
  always @(addr or busy_pull or tog or id_mode or locked or gen)
    dq_v = rd_val(addr);
  // Data only after access time, so a too early sample sees junk
  assign #(ACC_NS) dq_out = dq_v;
  assign #(ACC_NS) dq_drv = !ce_n && !oe_n && rst_n;
  always @(negedge oe_n)
    if (!ce_n && busy_pull)
      tog = ~tog;
  // Self-timed busy; a newer generation cancels a stale timer
  task automatic start_busy(input int ns);
    gen++;
    busy_pull = 1'b1;
    fork
      automatic int g = gen;
      begin
        #(ns);
        if (g == gen)
          busy_pull = 1'b0;
      end
    join_none
  endtask
  task automatic do_prog(input logic [18:0] a, input logic [15:0] d);
    hv_op = hv;
    if (!pwr_ok || (locked && blk(a) == 0 && !hv_op))
      return;
    {p_addr, p_data, erasing} = {a, d, 1'b0};
    mem[a] = (mem.exists(a) ? mem[a] : 16'hFFFF) & d;
    start_busy(PROG_NS);
  endtask
  task automatic do_erase(input int b, input logic chip);
    int ks[$];
    hv_op = hv;
    foreach (mem[k])
      if ((chip || blk(19'(k)) == b) &&
          !(blk(19'(k)) == 0 && locked && !hv_op))
        ks.push_back(k);
    foreach (ks[i])
      mem.delete(ks[i]);
    erasing = 1'b1;
    start_busy(ERASE_NS);
  endtask
  // One command bus cycle; only the low data byte of a command counts, a program word is taken whole
  task automatic cmd(input logic [18:0] a, input logic [15:0] d);
    logic a5, u1, u2;
    a5 = a[15:0] == 16'h5555;
    u1 = a5 && d[7:0] == 8'hAA;
    u2 = a[15:0] == 16'h2AAA && d[7:0] == 8'h55;
    if (busy_pull)
      return;
    if (arm)
    begin
      arm = 1'b0;
      do_prog(a, d);
      return;
    end
    if (d[7:0] == 8'hF0 && (step == 0 || (step == 2 && a5)))
      id_mode = 1'b0;
    case (step)
      0: step = u1 ? 1 : 0;
      1, 4: step = u2 ? step + 1 : 0;
      3: step = u1 ? 4 : 0;
      2:
      begin
        step = (a5 && d[7:0] == 8'h80) ? 3 : 0;
        arm = a5 && d[7:0] == 8'hA0;
        if (a5 && d[7:0] == 8'h90)
          id_mode = 1'b1;
      end
      default:
      begin
        step = 0;
        if (d[7:0] == 8'h30)
          do_erase(blk(a), 1'b0);
        else if (a5 && d[7:0] == 8'h10)
          do_erase(0, 1'b1);
        else if (a5 && d[7:0] == 8'h40)
          locked = 1'b1;
      end
    endcase
  endtask
  // Address at the later fall, data at the first rise
  always @(negedge we_n or negedge ce_n)
    if (!we_n && !ce_n)
      a_lat = addr;
  always @(posedge we_n or posedge ce_n)
    if ((we_n ^ ce_n) && oe_n && rst_n)
      cmd(a_lat, dq_in);
  // Reset aborts; an interrupted program leaves junk behind
  always @(negedge rst_n)
  begin
    if (busy_pull && !erasing)
      mem[p_addr] = ~p_data;
    {busy_pull, arm, id_mode, erasing} = '0;
    step = 0;
    gen++;
  end
endmodule // fep_flash_model

/* File: test/tb_fep_ctrl.sv */
`timescale 1ns/1ps
// ****************************************************************
// Bench for the flash command controller
// ****************************************************************
module tb_fep_ctrl
  import fep_pkg::*;
;
  localparam logic [18:0] MAIN_A = 19'h05000;
  localparam logic [18:0] MAIN_B = 19'h06000;
  localparam logic [18:0] BOOT_A = 19'h00010;
  localparam logic [18:0] BOOT_B = 19'h00020;
  localparam logic [15:0] DAT_A = 16'h1234;
  localparam logic [15:0] DAT_B = 16'h00FF;
  logic clk_sys, rst, avs_read, avs_write, avs_waitrequest;
  logic [2:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, r;
  logic [18:0] fl_addr;
  logic [15:0] fl_dq_o, dq_bus, mdl_dq;
  logic [15:0] dq_float = 16'h0000; // Undriven bus changes every cycle
  logic fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fl_rst_n, fl_hv_override;
  logic fl_busy_n, mdl_drv, mdl_pull;
  int failures, comparisons, n;
  // Bus wire: controller, then device, else floating junk
  assign dq_bus = fl_dq_oe ? fl_dq_o : mdl_drv ? mdl_dq : dq_float;
  assign fl_busy_n = mdl_pull ? 1'b0 : 1'b1; // Pull-up on the line
  always @(posedge clk_sys)
    dq_float <= ~dq_float;
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  fep_ctrl #(.PWRUP_CYCLES(20), .POLL_LIMIT(300)) fep_ctrl_i (
    .clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .fl_addr, .fl_dq_o, .fl_dq_oe,
    .fl_dq_i(dq_bus), .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_rst_n,
    .fl_hv_override, .fl_busy_n);
  fep_flash_model fep_flash_model_i (.addr(fl_addr), .dq_in(dq_bus),
    .ce_n(fl_ce_n), .oe_n(fl_oe_n), .we_n(fl_we_n), .rst_n(fl_rst_n),
    .hv(fl_hv_override), .dq_out(mdl_dq), .dq_drv(mdl_drv),
    .busy_pull(mdl_pull));
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One Avalon access; held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [2:0] idx,
    input logic [31:0] wd, output logic [31:0] rd);
    int k;
    avs_address <= idx;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
      if (k > 50)
      begin
        failures++;
        tally_and_finish();
      end
    end while (avs_waitrequest !== 1'b0);
    // Read data stands at the very edge that ends the wait
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys); // Request low for a cycle between accesses
  endtask
  task automatic wr(input logic [2:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask
  task automatic rd(input logic [2:0] idx, output logic [31:0] d);
    bus(1'b0, idx, 32'h0, d);
  endtask
  // Poll status until busy drops, bounded
  task automatic wait_idle(output logic [31:0] s);
    int k;
    k = 0;
    do
    begin
      rd(REG_STATUS, s);
      k++;
    end while (s[STS_BUSY] !== 1'b0 && k < 400);
  endtask
  task automatic run_op(input logic [2:0] op, input logic hv,
    input logic [18:0] a, input logic [15:0] d, input logic e);
    logic [31:0] s;
    wr(REG_STATUS, 32'h16);
    wr(REG_ADDR, {13'h0, a});
    wr(REG_WDATA, {16'h0, d});
    wr(REG_CTRL, {23'h0, hv, 5'h0, op});
    wait_idle(s);
    chk({29'h0, s[STS_BUSY], s[STS_DONE], s[STS_ERR]}, {30'h1, e});
  endtask
  task automatic flash_rd(input logic [18:0] a, input logic [15:0] d);
    logic [31:0] s;
    run_op(OP_READ, 1'b0, a, 16'h0, 1'b0);
    rd(REG_RDATA, s);
    chk(s, {16'h0, d});
  endtask
  initial
  begin
    #1000000;
    failures++;
    tally_and_finish();
  end
  initial
  begin
    rst = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    failures = 0;
    comparisons = 0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(REG_STATUS, r);
    chk(32'(r[STS_POWER]), 32'h1);
    chk(32'({fl_ce_n, fl_oe_n, fl_we_n, fl_rst_n}), 32'hF);
    rd(3'h7, r);
    chk(r, 32'h0);
    // A command during the power-up wait must not start
    wr(REG_CTRL, {29'h0, OP_LOCK});
    rd(REG_CTRL, r);
    chk(r, 32'h0);
    rd(REG_STATUS, r);
    for (n = 0; n < 100 && r[STS_POWER] !== 1'b0; n++)
      rd(REG_STATUS, r);
    chk(32'(r[STS_POWER]), 32'h0);
    run_op(OP_PROG, 1'b0, MAIN_A, DAT_A, 1'b0);
    flash_rd(MAIN_A, DAT_A);
    run_op(OP_PROG, 1'b0, MAIN_A, 16'hFFFF, 1'b1);
    flash_rd(MAIN_A, DAT_A);
    run_op(OP_PROG, 1'b0, BOOT_A, DAT_B, 1'b0);
    run_op(OP_SECT, 1'b0, MAIN_A, 16'h0, 1'b0);
    flash_rd(MAIN_A, 16'hFFFF);
    flash_rd(BOOT_A, DAT_B);
    run_op(OP_LOCK, 1'b0, 19'h0, 16'h0, 1'b0);
    run_op(OP_IDRD, 1'b0, 19'h00002, 16'h0, 1'b0);
    rd(REG_RDATA, r);
    chk(r, 32'h1);
    rd(REG_STATUS, r);
    chk(32'(r[STS_LOCK]), 32'h1);
    flash_rd(19'h00002, 16'hFFFF);
    run_op(OP_PROG, 1'b0, BOOT_B, DAT_A, 1'b1);
    flash_rd(BOOT_B, 16'hFFFF);
    run_op(OP_PROG, 1'b1, BOOT_B, DAT_A, 1'b0);
    rd(REG_ADDR, r);
    chk(r, {13'h0, BOOT_B});
    rd(REG_WDATA, r);
    chk(r, {16'h0, DAT_A});
    // Override drops again once the operation is over
    rd(REG_CTRL, r);
    chk(r, 32'h1);
    flash_rd(BOOT_B, DAT_A);
    run_op(OP_PROG, 1'b0, BOOT_A, 16'h000F, 1'b1);
    run_op(OP_PROG, 1'b0, MAIN_A, DAT_B, 1'b0);
    run_op(OP_CHIP, 1'b0, MAIN_B, 16'h0, 1'b0);
    flash_rd(MAIN_A, 16'hFFFF);
    flash_rd(BOOT_A, DAT_B);
    wr(REG_ADDR, {13'h0, MAIN_A});
    wr(REG_WDATA, {16'h0, DAT_A});
    wr(REG_CTRL, {29'h0, OP_PROG});
    // Ready pin as the controller reports it, not as the bench sees it
    rd(REG_STATUS, r);
    for (n = 0; n < 100 && r[STS_READY] !== 1'b0; n++)
      rd(REG_STATUS, r);
    chk(32'(r[STS_READY]), 32'h0);
    // A new command while busy is dropped; the last op stays
    wr(REG_CTRL, {29'h0, OP_READ});
    rd(REG_CTRL, r);
    chk(r, 32'h1);
    wr(REG_CTRL, {29'h0, OP_RESET});
    wait_idle(r);
    chk(32'(r[STS_CORRUPT]), 32'h1);
    chk(32'(r[STS_READY]), 32'h1);
    wr(REG_STATUS, 32'h10);
    rd(REG_STATUS, r);
    chk(32'(r[STS_CORRUPT]), 32'h0);
    flash_rd(BOOT_A, DAT_B);
    tally_and_finish();
  end
endmodule // tb_fep_ctrl
